// ---- maf_params.svh ----
`ifndef MAF_PARAMS_SVH
`define MAF_PARAMS_SVH

// Register byte offsets
`define MAF_OFS_CTRL     12'h000
`define MAF_OFS_COEF_A   12'h004
`define MAF_OFS_COEF_B   12'h008
`define MAF_OFS_RESULT   12'h00c
`define MAF_OFS_STATUS   12'h010

// Control register fields
`define MAF_CTRL_PROG_LSB   0
`define MAF_CTRL_FILT_LSB   2
`define MAF_CTRL_WIDTH_LSB  4
`define MAF_CTRL_LASER1_BIT 8
`define MAF_CTRL_LASER2_BIT 9

// Reset values
`define MAF_PROG_RESET   2'h0
`define MAF_FILT_RESET   2'h0
`define MAF_WIDTH_RESET  4'h1
`define MAF_LASER_RESET  2'h3
`define MAF_COEF_A_RESET 16'h0100
`define MAF_COEF_B_RESET 16'h0100

// Fixed-point fraction of the thickness coefficients
`define MAF_COEF_FRAC    8

// Largest window exponents and median taps
`define MAF_MAVG_MAX_LOG 4'h9
`define MAF_REC_MAX_LOG  4'hf
`define MAF_MED_MAX_TAPS 9

`endif

// ---- maf_pkg.sv ----
package maf_pkg;

  typedef enum logic [1:0] {
    PROG_SINGLE = 2'h0,
    PROG_THICK  = 2'h1,
    PROG_STEP   = 2'h2
  } program_t;

  typedef enum logic [1:0] {
    FILT_NONE   = 2'h0,
    FILT_MAVG   = 2'h1,
    FILT_REC    = 2'h2,
    FILT_MEDIAN = 2'h3
  } filter_t;

endpackage : maf_pkg

// ---- median_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface median_if #(
  parameter int W = 32
) ();
  logic signed [W-1:0] sample;
  logic                valid;
  logic                clear;
  logic [3:0]          taps;
  logic signed [W-1:0] median;
  logic                median_valid;

  modport filt (input sample, input valid, input clear, input taps,
                output median, output median_valid);
  modport ctrl (output sample, output valid, output clear, output taps,
                input median, input median_valid);
endinterface : median_if

`default_nettype wire

// ---- median_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "maf_params.svh"

module median_filter
  import maf_pkg::*;
#(
  parameter int W    = 32,
  parameter int MAXN = `MAF_MED_MAX_TAPS
) (
  input  wire logic clock,
  input  wire logic rst_n,
  median_if.filt    m
);

  logic signed [W-1:0] win_ff  [MAXN];
  logic signed [W-1:0] nxt_win [MAXN];
  logic signed [W-1:0] med_ff;
  logic                med_valid_ff;
  logic signed [W-1:0] nxt_med;

  // Window after the incoming sample has been shifted in
  always_comb begin
    nxt_win[0] = m.sample;
    for (int i = 1; i < MAXN; i++) begin
      nxt_win[i] = win_ff[i-1];
    end
  end

  // Rank sort: ties broken by position so exactly one entry owns each rank
  always_comb begin
    int rank;
    rank    = 0;
    nxt_med = '0;
    for (int i = 0; i < MAXN; i++) begin
      rank = 0;
      for (int j = 0; j < MAXN; j++) begin
        if (j < int'(m.taps) && i < int'(m.taps) &&
            ((nxt_win[j] < nxt_win[i]) || (nxt_win[j] == nxt_win[i] && j < i))) begin
          rank = rank + 1;
        end
      end
      if (i < int'(m.taps) && rank == int'(m.taps) / 2) begin
        nxt_med = nxt_win[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MAXN; i++) win_ff[i] <= '0;
    end else if (m.clear) begin
      for (int i = 0; i < MAXN; i++) win_ff[i] <= '0;
    end else if (m.valid) begin
      for (int i = 0; i < MAXN; i++) win_ff[i] <= nxt_win[i];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      med_ff       <= '0;
      med_valid_ff <= 1'b0;
    end else begin
      med_valid_ff <= m.valid && !m.clear;
      if (m.valid && !m.clear) med_ff <= nxt_med;
    end
  end

  assign m.median       = med_ff;
  assign m.median_valid = med_valid_ff;

endmodule : median_filter

`default_nettype wire

// ---- measurement_averaging_filter.sv ----
// Overview of operation
// - Software picks no smoothing, moving average, recursive average or median, plus a width.
// - Moving average outputs the mean of the latest N samples, oldest leaving as newest enters.
// - Moving-average N is a power of two from 2 to 512 so the divide is a shift.
// - Recursive output is (new sample + (N-1) x previous output) / N, a low-pass.
// - Recursive N is a power of two from 2 to 32768.
// - Median sorts the latest N samples (N = 3, 5, 7 or 9) each time and outputs the middle.
// - Single-channel program passes the channel one distance to the result.
// - Thickness program outputs coefficient A x channel one plus coefficient B x channel two.
// - Step program outputs channel one minus channel two as a height.
// - The chosen program is held and the default program applies after power-up.
// - A laser on/off control is driven to each sensor, which obeys it.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "maf_params.svh"

module measurement_averaging_filter
  import maf_pkg::*;
#(
  parameter int DW      = 16,
  parameter int RW      = 32,
  parameter int MAVG_N  = 512
) (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [DW-1:0]        channel_one_distance,
  input  wire logic [DW-1:0]        channel_two_distance,
  input  wire logic                 sample_strobe,
  output logic signed [RW-1:0]      result,
  output logic                      result_valid,
  output logic [1:0]                laser_on
);

  localparam int PW = $clog2(MAVG_N);
  localparam int AW = RW + 16;

  // Exponent clamped into [1, max]
  function automatic logic [3:0] clamp_log(input logic [3:0] code, input logic [3:0] lim);
    logic [3:0] r;
    r = code;
    if (r == 4'h0) r = 4'h1;
    if (r > lim) r = lim;
    return r;
  endfunction : clamp_log

  // Median taps: codes 1..4 give 3, 5, 7, 9; others clamp
  function automatic logic [3:0] med_taps(input logic [3:0] code);
    logic [3:0] c;
    c = code;
    if (c == 4'h0) c = 4'h1;
    if (c > 4'h4) c = 4'h4;
    return 4'((c << 1) + 4'h1);
  endfunction : med_taps

  // Reset release
  logic rst_s1_ff;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  // Registers
  program_t         prog_ff;
  filter_t          filt_ff;
  logic [3:0]       width_ff;
  logic [1:0]       laser_ff;
  logic signed [15:0] coef_a_ff;
  logic signed [15:0] coef_b_ff;
  logic             clear_ff;
  logic [15:0]      sample_cnt_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;

  logic setup;
  logic wr_en;
  logic rd_en;
  logic mapped;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready_ff && pwrite;
  assign rd_en  = setup && !pwrite;
  assign mapped = (paddr == `MAF_OFS_CTRL) || (paddr == `MAF_OFS_COEF_A) ||
                  (paddr == `MAF_OFS_COEF_B) || (paddr == `MAF_OFS_RESULT) ||
                  (paddr == `MAF_OFS_STATUS);

  // Zero-wait slave: ready in every access phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
    end
  end

  // Program held in a register; reset gives the default program
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_ff <= program_t'(`MAF_PROG_RESET);
    end else if (wr_en && paddr == `MAF_OFS_CTRL) begin
      prog_ff <= program_t'(pwdata[`MAF_CTRL_PROG_LSB +: 2]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filt_ff  <= filter_t'(`MAF_FILT_RESET);
      width_ff <= `MAF_WIDTH_RESET;
      clear_ff <= 1'b0;
    end else begin
      clear_ff <= 1'b0;
      if (wr_en && paddr == `MAF_OFS_CTRL) begin
        filt_ff  <= filter_t'(pwdata[`MAF_CTRL_FILT_LSB +: 2]);
        width_ff <= pwdata[`MAF_CTRL_WIDTH_LSB +: 4];
        clear_ff <= (pwdata[`MAF_CTRL_FILT_LSB +: 2] != filt_ff) ||
                    (pwdata[`MAF_CTRL_WIDTH_LSB +: 4] != width_ff);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      laser_ff <= `MAF_LASER_RESET;
    end else if (wr_en && paddr == `MAF_OFS_CTRL) begin
      laser_ff <= {pwdata[`MAF_CTRL_LASER2_BIT], pwdata[`MAF_CTRL_LASER1_BIT]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coef_a_ff <= `MAF_COEF_A_RESET;
      coef_b_ff <= `MAF_COEF_B_RESET;
    end else if (wr_en) begin
      if (paddr == `MAF_OFS_COEF_A) coef_a_ff <= pwdata[15:0];
      if (paddr == `MAF_OFS_COEF_B) coef_b_ff <= pwdata[15:0];
    end
  end

  // Sample strobe from the sensors: three-stage sync, edge on agreement
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic strobe_lvl_ff;
  logic new_sample;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff         <= 1'b0;
      s2_ff         <= 1'b0;
      s3_ff         <= 1'b0;
      strobe_lvl_ff <= 1'b0;
    end else begin
      s1_ff <= sample_strobe;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) strobe_lvl_ff <= s3_ff;
    end
  end

  assign new_sample = (s2_ff == s3_ff) && s3_ff && !strobe_lvl_ff;

  // Stage 1: measuring program. Distances must stay stable while the strobe is high.
  logic signed [RW-1:0] comb_ff;
  logic                 comb_valid_ff;
  logic signed [DW:0]   d1;
  logic signed [DW:0]   d2;
  logic signed [DW+17:0] thick_sum;
  logic signed [RW-1:0] nxt_comb;

  assign d1 = {1'b0, channel_one_distance};
  assign d2 = {1'b0, channel_two_distance};
  assign thick_sum = (DW+18)'(coef_a_ff * d1) + (DW+18)'(coef_b_ff * d2);

  always_comb begin
    unique case (prog_ff)
      PROG_THICK: nxt_comb = RW'(thick_sum >>> `MAF_COEF_FRAC);
      PROG_STEP:  nxt_comb = RW'(d1 - d2);
      default:    nxt_comb = RW'(d1);
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comb_ff       <= '0;
      comb_valid_ff <= 1'b0;
    end else begin
      comb_valid_ff <= new_sample;
      if (new_sample) comb_ff <= nxt_comb;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt_ff <= '0;
    end else if (comb_valid_ff) begin
      sample_cnt_ff <= sample_cnt_ff + 16'h0001;
    end
  end

  // Moving average: ring buffer with running sum
  logic signed [RW-1:0] mavg_mem [MAVG_N];
  logic [PW-1:0]        wptr_ff;
  logic [PW:0]          fill_ff;
  logic signed [AW-1:0] msum_ff;
  logic signed [RW-1:0] mavg_ff;
  logic [3:0]           mk;
  logic [PW:0]          mn;
  logic signed [RW-1:0] oldest;
  logic signed [AW-1:0] nxt_msum;

  assign mk = clamp_log(width_ff, `MAF_MAVG_MAX_LOG);
  assign mn = (PW+1)'(1) << mk;
  // Until the window has filled, missing entries count as zero
  assign oldest   = (fill_ff >= mn) ? mavg_mem[PW'(wptr_ff - mn[PW-1:0])] : '0;
  assign nxt_msum = msum_ff + AW'(comb_ff) - AW'(oldest);

  always_ff @(posedge clock) begin
    if (comb_valid_ff) mavg_mem[wptr_ff] <= comb_ff;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff <= '0;
      fill_ff <= '0;
      msum_ff <= '0;
      mavg_ff <= '0;
    end else if (clear_ff) begin
      wptr_ff <= '0;
      fill_ff <= '0;
      msum_ff <= '0;
    end else if (comb_valid_ff) begin
      wptr_ff <= wptr_ff + PW'(1);
      if (fill_ff < mn) fill_ff <= fill_ff + (PW+1)'(1);
      msum_ff <= nxt_msum;
      mavg_ff <= RW'(nxt_msum >>> mk);
    end
  end

  // Recursive average: acc holds N x output at full precision,
  // so acc' = x + (N-1) x M = acc + x - M with no rounding drift.
  logic signed [AW-1:0] racc_ff;
  logic                 rprimed_ff;
  logic signed [RW-1:0] rec_ff;
  logic [3:0]           rk;
  logic signed [AW-1:0] nxt_racc;

  assign rk = clamp_log(width_ff, `MAF_REC_MAX_LOG);
  assign nxt_racc = rprimed_ff ? (racc_ff + AW'(comb_ff) - (racc_ff >>> rk))
                               : (AW'(comb_ff) <<< rk);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      racc_ff    <= '0;
      rprimed_ff <= 1'b0;
      rec_ff     <= '0;
    end else if (clear_ff) begin
      racc_ff    <= '0;
      rprimed_ff <= 1'b0;
    end else if (comb_valid_ff) begin
      racc_ff    <= nxt_racc;
      rprimed_ff <= 1'b1;
      rec_ff     <= RW'(nxt_racc >>> rk);
    end
  end

  // Median
  median_if #(.W(RW)) med ();

  assign med.sample = comb_ff;
  assign med.valid  = comb_valid_ff;
  assign med.clear  = clear_ff;
  assign med.taps   = med_taps(width_ff);

  median_filter #(
    .W    (RW),
    .MAXN (`MAF_MED_MAX_TAPS)
  ) u_median (
    .clock (clock),
    .rst_n (rst_n),
    .m     (med)
  );

  // Stage 2 bypass and valid
  logic signed [RW-1:0] pass_ff;
  logic                 f2_valid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pass_ff     <= '0;
      f2_valid_ff <= 1'b0;
    end else begin
      f2_valid_ff <= comb_valid_ff && !clear_ff;
      if (comb_valid_ff) pass_ff <= comb_ff;
    end
  end

  // Stage 3: output select
  logic signed [RW-1:0] result_ff;
  logic                 result_valid_ff;
  logic signed [RW-1:0] nxt_result;

  always_comb begin
    unique case (filt_ff)
      FILT_MAVG:   nxt_result = mavg_ff;
      FILT_REC:    nxt_result = rec_ff;
      FILT_MEDIAN: nxt_result = med.median;
      default:     nxt_result = pass_ff;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_ff       <= '0;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= f2_valid_ff;
      if (f2_valid_ff) result_ff <= nxt_result;
    end
  end

  // Read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= '0;
    end else if (rd_en) begin
      unique case (paddr)
        `MAF_OFS_CTRL:   prdata_ff <= {22'h0, laser_ff, width_ff, filt_ff, prog_ff};
        `MAF_OFS_COEF_A: prdata_ff <= {16'h0, coef_a_ff};
        `MAF_OFS_COEF_B: prdata_ff <= {16'h0, coef_b_ff};
        `MAF_OFS_RESULT: prdata_ff <= 32'(result_ff);
        `MAF_OFS_STATUS: prdata_ff <= {16'h0, sample_cnt_ff};
        default:         prdata_ff <= '0;
      endcase
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign result       = result_ff;
  assign result_valid = result_valid_ff;
  assign laser_on     = laser_ff;

endmodule : measurement_averaging_filter

`default_nettype wire

// ---- maf_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module maf_assertions #(
  parameter int DW = 16,
  parameter int RW = 32
) (
  input wire logic                 clock,
  input wire logic                 nrst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [DW-1:0]        channel_one_distance,
  input wire logic [DW-1:0]        channel_two_distance,
  input wire logic                 sample_strobe,
  input wire logic signed [RW-1:0] result,
  input wire logic                 result_valid,
  input wire logic [1:0]           laser_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence ctrl_wr;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence

  sequence strobe_rise;
    $rose(sample_strobe);
  endsequence

  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  chk_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  chk_laser_write: assert property (ctrl_wr |=> laser_on == $past(pwdata[9:8]))
    else $error("laser control not taken");
  chk_laser_hold: assert property ($changed(laser_on) |-> $past(psel && penable && pwrite))
    else $error("laser control moved by itself");
  chk_reset_defaults: assert property ($rose(nrst) |-> laser_on == 2'b11 && !result_valid)
    else $error("wrong state after reset");
  chk_result_latency: assert property (strobe_rise |-> ##[4:9] result_valid)
    else $error("no result after sample");
  chk_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  chk_result_hold: assert property ($changed(result) |-> result_valid)
    else $error("result changed without valid");
endmodule : maf_assertions

bind measurement_averaging_filter maf_assertions #(.DW(DW), .RW(RW)) maf_assertions_inst (
  .clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .channel_one_distance, .channel_two_distance, .sample_strobe, .result, .result_valid,
  .laser_on);

`default_nettype wire

// ---- sensor_pair.sv ----
`timescale 1ns/1ps
`default_nettype none

module sensor_pair (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic [15:0] d1,
  input  wire logic [15:0] d2,
  input  wire logic [1:0]  laser_on,
  output logic      [15:0] channel_one_distance,
  output logic      [15:0] channel_two_distance,
  output logic             sample_strobe
);
  logic [3:0]  cnt_ff;
  logic [15:0] m1_ff;
  logic [15:0] m2_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
      m1_ff  <= 16'h0;
      m2_ff  <= 16'h0;
    end else if (req) begin
      cnt_ff <= 4'h9;
      m1_ff  <= d1;
      m2_ff  <= d2;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // High five cycles, then a low gap of four
  assign sample_strobe = cnt_ff > 4'h4;

  // Data valid around the strobe only; a dark sensor reads zero
  always_comb begin
    channel_one_distance = (cnt_ff > 4'h2) ? m1_ff : ~m1_ff;
    channel_two_distance = (cnt_ff > 4'h2) ? m2_ff : ~m2_ff;
    if (!laser_on[0]) channel_one_distance = 16'h0;
    if (!laser_on[1]) channel_two_distance = 16'h0;
  end
endmodule : sensor_pair

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic               clock = 1'b0;
  logic               nrst = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [15:0]        channel_one_distance;
  logic [15:0]        channel_two_distance;
  logic               sample_strobe;
  logic signed [31:0] result;
  logic               result_valid;
  logic [1:0]         laser_on;
  logic               req = 1'b0;
  logic [15:0]        d1 = 16'h0;
  logic [15:0]        d2 = 16'h0;
  logic [31:0]        q;
  logic               err;
  int                 n_errors = 0;
  int                 num_checks = 0;

  always #5 clock = ~clock;

  measurement_averaging_filter measurement_averaging_filter_inst (
    .clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .channel_one_distance, .channel_two_distance, .sample_strobe, .result, .result_valid,
    .laser_on);

  sensor_pair sensor_pair_inst (
    .clock, .nrst, .req, .d1, .d2, .laser_on, .channel_one_distance,
    .channel_two_distance, .sample_strobe);

  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic e_err);
    apb(1'b0, a, 32'h0);
    check(q, e);
    check({31'h0, err}, {31'h0, e_err});
  endtask : rd

  task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
    int n;
    req <= 1'b1;
    d1 <= a;
    d2 <= b;
    @(posedge clock);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (result_valid !== 1'b1 && n < 30);
    if (result_valid !== 1'b1) n_errors++;
    check(result, e);
    repeat (12) @(posedge clock);
  endtask : smp

  // Settle the setting, then feed up to five samples on channel one
  task automatic seq(input logic [31:0] ctrl, input int n, input logic [15:0] b,
                     input logic [15:0] a[5], input logic [31:0] e[5]);
    apb(1'b1, 12'h000, ctrl);
    for (int i = 0; i < n; i++) smp(a[i], b, e[i]);
  endtask : seq

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    check({30'h0, laser_on}, 32'h3);
    rd(12'h000, 32'h0000_0310, 1'b0);
    rd(12'h004, 32'h0000_0100, 1'b0);
    rd(12'h008, 32'h0000_0100, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0200);
    seq(32'h300, 1, 16'd30, '{100, 0, 0, 0, 0}, '{100, 0, 0, 0, 0});
    seq(32'h301, 1, 16'd30, '{100, 0, 0, 0, 0}, '{230, 0, 0, 0, 0});
    seq(32'h302, 2, 16'd30, '{100, 10, 0, 0, 0}, '{70, -20, 0, 0, 0});
    seq(32'h303, 1, 16'd30, '{100, 0, 0, 0, 0}, '{100, 0, 0, 0, 0});
    seq(32'h314, 3, 16'd1, '{10, 20, 30, 0, 0}, '{5, 15, 25, 0, 0});
    seq(32'h324, 4, 16'd1, '{8, 8, 8, 8, 0}, '{2, 4, 6, 8, 0});
    seq(32'h394, 1, 16'd1, '{1024, 0, 0, 0, 0}, '{2, 0, 0, 0, 0});
    seq(32'h3a4, 1, 16'd1, '{1024, 0, 0, 0, 0}, '{2, 0, 0, 0, 0});
    seq(32'h318, 3, 16'd1, '{10, 20, 30, 0, 0}, '{10, 15, 22, 0, 0});
    seq(32'h3f8, 2, 16'd1, '{1000, 0, 0, 0, 0}, '{1000, 999, 0, 0, 0});
    seq(32'h31c, 4, 16'd1, '{5, 1, 3, 9, 0}, '{0, 1, 3, 3, 0});
    seq(32'h32c, 5, 16'd1, '{2, 4, 5, 1, 3}, '{0, 0, 2, 2, 3});
    seq(32'h33c, 5, 16'd1, '{9, 9, 9, 9, 9}, '{0, 0, 0, 9, 9});
    seq(32'h34c, 5, 16'd1, '{7, 7, 7, 7, 7}, '{0, 0, 0, 0, 7});
    seq(32'h200, 1, 16'd1, '{55, 0, 0, 0, 0}, '{0, 0, 0, 0, 0});
    check({30'h0, laser_on}, 32'h2);
    apb(1'b1, 12'h00c, 32'h0000_1234);
    rd(12'h00c, 32'h0, 1'b0);
    rd(12'h010, 32'h0000_0027, 1'b0);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
